/* bench/aux_io_chk.sv */
`timescale 1ns/1ns
module aux_io_chk
    import aux_io_pkg::*;
(
    // watched ports
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire reg_req_t    i_req,
    input  wire logic        i_latch_cmd,
    input  wire logic [7:0]  o_rdata,
    input  wire code12_t     i_adc_code,
    input  wire code12_t     o_dac_code,
    input  wire line_claim_t i_alarm_line [2],
    input  wire line_claim_t i_misc_line  [2],
    input  wire logic [1:0]  o_line_out,
    input  wire logic [1:0]  o_line_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence rd_at(a);
        i_ce && i_req.addr == a;
    endsequence
    dac_hold_a: assert property (i_ce && !i_latch_cmd |=> $stable(o_dac_code))
        else $error("dac moved");
    adc_low_a: assert property (rd_at(8'h0a) |=> o_rdata == $past(i_adc_code[7:0]))
        else $error("adc low");
    adc_high_a: assert property (rd_at(8'h0b) |=> o_rdata == {4'h0, $past(i_adc_code[11:8])})
        else $error("adc high");
    unused_zero_a: assert property (rd_at(8'h31) or rd_at(8'h33) |=> o_rdata[7:4] == 4'h0)
        else $error("unused bits");
    unmapped_a: assert property (i_ce && !(i_req.addr inside {8'h0a, 8'h0b, [8'h30:8'h33]})
        |=> o_rdata == 8'h00) else $error("unmapped read");
    misc_wins_a: assert property (i_ce && i_misc_line[1].claim
        |=> o_line_oe[1] && o_line_out[1] == $past(i_misc_line[1].level)) else $error("misc");
    alarm_wins_a: assert property (i_ce && i_alarm_line[1].claim && !i_misc_line[1].claim
        |=> o_line_oe[1] && o_line_out[1] == $past(i_alarm_line[1].level)) else $error("alarm");
    reset_val_a: assert property ($rose(i_rstn) |-> o_dac_code == 12'h000 && o_line_oe == 2'h0)
        else $error("reset state");
endmodule
bind aux_io_ctrl aux_io_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_req(i_req),
    .i_latch_cmd(i_latch_cmd), .o_rdata(o_rdata), .i_adc_code(i_adc_code),
    .o_dac_code(o_dac_code), .i_alarm_line(i_alarm_line), .i_misc_line(i_misc_line),
    .o_line_out(o_line_out), .o_line_oe(o_line_oe));

/* bench/line_pullup.sv */
`timescale 1ns/1ns
module line_pullup (
    // pin drive and resolved level
    input  wire logic [1:0] i_oe,
    input  wire logic [1:0] i_out,
    output logic [1:0]      o_pin
);
    // released line floats to the internal pull-up
    assign o_pin = i_out | ~i_oe;
endmodule

/* bench/tb.sv */
`timescale 1ns/1ns
module tb import aux_io_pkg::*; ;
    logic        i_clk = 0, i_rstn = 0, latch = 0, ce = 1;
    reg_req_t    req = '0;
    code12_t     adc = '0, dac;
    line_claim_t alm [2] = '{default: '0};
    line_claim_t msc [2] = '{default: '0};
    logic [7:0]  rdata;
    logic [1:0]  pin, out, oe, inval;
    int          n_fail = 0, cmp_count = 0;
    aux_io_ctrl DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_req(req),
        .i_latch_cmd(latch), .o_rdata(rdata), .i_adc_code(adc), .o_dac_code(dac),
        .i_alarm_line(alm), .i_misc_line(msc), .i_line_in(pin), .o_line_out(out),
        .o_line_oe(oe), .o_line_in_val(inval));
    line_pullup u_pull (.i_oe(oe), .i_out(out), .o_pin(pin));
    initial forever #5 i_clk = ~i_clk;
    task automatic cmp(input logic [11:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_clk) req <= '{1'b1, a, d};
        @(posedge i_clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge i_clk) req <= '{1'b0, a, 8'h00};
        step();
        cmp({4'h0, rdata}, {4'h0, e});
    endtask
    task automatic lat(input logic [11:0] e);
        @(posedge i_clk) latch <= 1'b1;
        @(posedge i_clk) latch <= 1'b0;
        #1 cmp(dac, e);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard well above the sequence length
    initial begin
        #20000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(8'h30, 8'h00);
        rd(8'h33, 8'h00);
        cmp({10'h0, oe}, 12'h000);
        $display("reset test done");
        wr(8'h30, 8'hab);
        wr(8'h31, 8'hfc);
        step();
        cmp(dac, 12'h000);
        rd(8'h31, 8'h0c);
        lat(12'hcab);
        wr(8'h30, 8'hff);
        wr(8'h31, 8'h0f);
        lat(12'hfff);
        // enable low must freeze the register against a write
        @(posedge i_clk) ce <= 1'b0;
        wr(8'h30, 8'h55);
        @(posedge i_clk) ce <= 1'b1;
        rd(8'h30, 8'hff);
        rd(8'h40, 8'h00);
        $display("level test done");
        wr(8'h32, 8'hff);
        wr(8'h33, 8'hff);
        step();
        cmp({8'h0, oe, out}, 12'h00f);
        rd(8'h32, 8'h03);
        wr(8'h33, 8'h01);
        step();
        cmp({10'h0, out}, 12'h001);
        step();
        cmp({10'h0, inval}, 12'h001);
        wr(8'h32, 8'h01);
        step();
        cmp({8'h0, oe, pin}, 12'h007);
        @(posedge i_clk) alm[1] <= '{1'b1, 1'b0};
        step();
        cmp({8'h0, oe, out}, 12'h00d);
        @(posedge i_clk) msc[1] <= '{1'b1, 1'b1};
        step();
        cmp({8'h0, oe, out}, 12'h00f);
        $display("line test done");
        @(posedge i_clk) adc <= 12'habc;
        rd(8'h0a, 8'hbc);
        rd(8'h0b, 8'h0a);
        $display("adc test done");
        end_of_test();
    end
endmodule

/* hdl/aux_io_cfg.svh */
`ifndef AUX_IO_CFG_SVH
`define AUX_IO_CFG_SVH

// byte addresses of the register pairs (low byte even)
`define AUX_LEVEL_LO_ADDR   8'h30
`define AUX_LEVEL_HI_ADDR   8'h31
`define IO_SETUP_LO_ADDR    8'h32
`define IO_SETUP_HI_ADDR    8'h33
`define ADC_RESULT_LO_ADDR  8'h0a
`define ADC_RESULT_HI_ADDR  8'h0b

// reset values
`define AUX_LEVEL_RESET     16'h0000
`define IO_SETUP_RESET      16'h0000

// field layout
`define AUX_CODE_MSB        11
`define IO_DIR_LSB          0
`define IO_LEVEL_LSB        8
`define IO_LINE_COUNT       2
`define LATCH_CMD_BIT       2

// writable bit masks per byte
`define AUX_LEVEL_HI_MASK   8'h0f
`define IO_SETUP_LO_MASK    8'h03
`define IO_SETUP_HI_MASK    8'h03

`endif

/* hdl/aux_io_ctrl.sv */
// What this block does
// R1 - adc result read as unsigned 12-bit binary
// R2 - host writes both bytes before latching
// R3 - command bit 2 latches code into converter
// R4 - byte writes never change converter input
// R5 - code 0 to 0xfff spans range linearly
// R6 - level code in bits 11:0, rest unused
// R7 - level register read-write, clears on reset
// R8 - data-ready beats alarm beats setup register
// R9 - bits 1:0 set line direction
// R10 - bits 9:8 set driven line level
// R11 - setup register clears to inputs on reset
// R12 - inputs undriven, unused bits read zero
`timescale 1ns/1ns
`include "aux_io_cfg.svh"

module aux_io_ctrl
    import aux_io_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    // register access from the serial interface
    input  wire reg_req_t    i_req,
    input  wire logic        i_latch_cmd,
    output logic [7:0]       o_rdata,
    // auxiliary converters
    input  wire code12_t     i_adc_code,
    output code12_t          o_dac_code,
    // competing line functions
    input  wire line_claim_t i_alarm_line [`IO_LINE_COUNT],
    input  wire line_claim_t i_misc_line  [`IO_LINE_COUNT],
    // io lines
    input  wire logic [1:0]  i_line_in,
    output logic [1:0]       o_line_out,
    output logic [1:0]       o_line_oe,
    output logic [1:0]       o_line_in_val
);

    logic [15:0] level_ff;
    logic [15:0] nxt_level;
    logic [15:0] setup_ff;
    logic [15:0] nxt_setup;
    code12_t     dac_ff;
    code12_t     nxt_dac;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [1:0]  out_ff;
    logic [1:0]  oe_ff;
    logic [1:0]  inval_ff;
    logic [1:0]  mux_out;
    logic [1:0]  mux_oe;

    // register writes; each byte lands on its own, the converter is untouched
    always_comb begin
        nxt_level = level_ff;
        nxt_setup = setup_ff;
        if (i_req.wr) begin
            unique case (i_req.addr)
                `AUX_LEVEL_LO_ADDR:
                    nxt_level[7:0]  = i_req.wdata;                         // see R7
                `AUX_LEVEL_HI_ADDR:
                    nxt_level[15:8] = i_req.wdata & `AUX_LEVEL_HI_MASK;    // see R6 see R12
                `IO_SETUP_LO_ADDR:
                    nxt_setup[7:0]  = i_req.wdata & `IO_SETUP_LO_MASK;     // see R9 see R12
                `IO_SETUP_HI_ADDR:
                    nxt_setup[15:8] = i_req.wdata & `IO_SETUP_HI_MASK;     // see R10 see R12
                default: ;
            endcase
        end
    end

    // converter input only moves on the latch command, both bytes at once
    always_comb begin
        nxt_dac = dac_ff;                                                  // see R4
        if (i_latch_cmd) begin
            // latch takes the level register after any same-cycle byte write
            nxt_dac = nxt_level[`AUX_CODE_MSB:0];                          // see R3 see R5
        end
    end

    // read mux; unmapped addresses and unused bits read zero
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (i_req.addr)
            `AUX_LEVEL_LO_ADDR:  nxt_rdata = level_ff[7:0];
            `AUX_LEVEL_HI_ADDR:  nxt_rdata = level_ff[15:8];
            `IO_SETUP_LO_ADDR:   nxt_rdata = setup_ff[7:0];
            `IO_SETUP_HI_ADDR:   nxt_rdata = setup_ff[15:8];
            `ADC_RESULT_LO_ADDR: nxt_rdata = i_adc_code[7:0];              // see R1
            `ADC_RESULT_HI_ADDR: nxt_rdata = {4'h0, i_adc_code[11:8]};     // see R1
            default:             nxt_rdata = 8'h00;                        // see R12
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            level_ff <= `AUX_LEVEL_RESET;                                  // see R7
            setup_ff <= `IO_SETUP_RESET;                                   // see R11
            dac_ff   <= 12'h000;
            rdata_ff <= 8'h00;
        end else if (i_ce) begin
            level_ff <= nxt_level;
            setup_ff <= nxt_setup;
            dac_ff   <= nxt_dac;
            rdata_ff <= nxt_rdata;
        end
    end

    // one priority resolver per line
    genvar g;
    generate
        for (g = 0; g < `IO_LINE_COUNT; g++) begin : g_line
            io_line_mux u_mux (
                .i_dir   (setup_ff[`IO_DIR_LSB + g]),
                .i_level (setup_ff[`IO_LEVEL_LSB + g]),
                .i_alarm (i_alarm_line[g]),
                .i_misc  (i_misc_line[g]),
                .o_oe    (mux_oe[g]),
                .o_out   (mux_out[g])
            );
        end
    endgenerate

    // pins are registered so every output comes from a flip-flop
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_ff   <= 2'h0;
            oe_ff    <= 2'h0;                                              // see R11
            inval_ff <= 2'h0;
        end else if (i_ce) begin
            out_ff   <= mux_out;
            oe_ff    <= mux_oe;                                            // see R12
            inval_ff <= i_line_in;
        end
    end

    assign o_rdata       = rdata_ff;
    assign o_dac_code    = dac_ff;
    assign o_line_out    = out_ff;
    assign o_line_oe     = oe_ff;
    assign o_line_in_val = inval_ff;

endmodule

/* hdl/aux_io_pkg.sv */
package aux_io_pkg;

    typedef logic [11:0] code12_t;

    // one byte-wide register access from the serial interface logic
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // per-line requests from the alarm and data-ready functions
    typedef struct packed {
        logic claim;
        logic level;
    } line_claim_t;

endpackage

/* hdl/io_line_mux.sv */
`timescale 1ns/1ns
`include "aux_io_cfg.svh"

module io_line_mux
    import aux_io_pkg::*;
(
    // setup register bits for this line
    input  wire logic        i_dir,
    input  wire logic        i_level,
    // competing functions
    input  wire line_claim_t i_alarm,
    input  wire line_claim_t i_misc,
    // resolved drive
    output logic             o_oe,
    output logic             o_out
);

    always_comb begin
        if (i_misc.claim) begin                 // see R8
            o_oe  = 1'b1;
            o_out = i_misc.level;
        end else if (i_alarm.claim) begin       // see R8
            o_oe  = 1'b1;
            o_out = i_alarm.level;
        end else begin
            o_oe  = i_dir;                      // see R9 see R12
            o_out = i_dir & i_level;            // see R10
        end
    end

endmodule
